// ===== common/osc_pkg.sv
package osc_pkg;
    // Command codes
    localparam logic [15:0] CMD_SHAPE_DRAW = 16'h8218;
    localparam logic [15:0] CMD_PALETTE_WRITE = 16'h8219;
    localparam logic [15:0] CMD_GLYPH_WRITE = 16'h821A;
    // Result codes
    localparam logic [7:0] RES_SUCCESS = 8'h00;
    localparam logic [7:0] RES_INVALID = 8'h01;
    localparam logic [7:0] RES_BUSY = 8'h02;
    // Parameter pool
    localparam int POOL_CAP = 128;
    localparam int POOL_AW = 7;
    localparam logic [7:0] POOL_CAP_B = 8'h80;
    localparam logic [15:0] GLYPH_LEN_MAX = 16'h007C;
    // Descriptor layout
    localparam logic [7:0] DESC_END = 8'h00;
    localparam logic [7:0] DESC_LINE = 8'hC1;
    localparam logic [7:0] DESC_ARC = 8'hC2;
    localparam logic [7:0] LINE_LEN = 8'h0C;
    localparam logic [7:0] ARC_LEN = 8'h16;
    localparam logic [3:0] OVL_MAX = 4'h1;
    localparam logic [3:0] LINE_ENG_MAX = 4'h9;
    localparam logic [3:0] ARC_ENG_MAX = 4'h4;
    localparam int CW_BOX = 10;
    localparam int CW_VALID = 9;
    localparam int CW_AA = 8;
    localparam int CW_WID_LSB = 4;
    // Palette and glyph memory
    localparam logic [4:0] PAL_ENTRIES = 5'h10;
    localparam logic [7:0] PAL_HDR_LEN = 8'h04;
    localparam logic [16:0] GLYPH_BYTES = 17'h02000;
    localparam int GLYPH_CHAR_LSB = 7;
    localparam logic [7:0] GLYPH_INDEX_BASE = 8'hC0;
    // Register offsets
    localparam logic [7:0] REG_CMD = 8'h00;
    localparam logic [7:0] REG_PARAM = 8'h04;
    localparam logic [7:0] REG_STATUS = 8'h08;
    localparam logic [7:0] REG_CTRL = 8'h0C;
    // Reset values
    localparam logic [15:0] CMD_RST = 16'h0000;
    localparam logic [7:0] RES_RST = 8'h00;
    localparam logic CTRL_RST = 1'b0;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_SHAPE_CHECK,
        ST_SHAPE_APPLY,
        ST_PAL_CHECK,
        ST_PAL_WRITE,
        ST_GLY_CHECK,
        ST_GLY_WRITE,
        ST_DONE
    } osc_state_t;
endpackage

// ===== rtl/osc_unit.sv
// Added by the designer: the plain strobed port and the placing of the registers.
`timescale 1ns/1ns
//
// Contract
// - Command 8218h parses shape descriptors and programs line and arc engines.
// - Descriptor list ends at a zero byte; parsing stops there.
// - Success when all descriptors accepted, invalid for any bad descriptor.
// - Engine values are computed first, applied only during frame blanking.
// - No calibration offset; coordinates pass through, origin top-left.
// - Line descriptor: 12 bytes, type C1h, overlay/engine nibbles, big-endian.
// - Line overlay 0..1, engine 0..9, width 1..16, else invalid.
// - Line control: valid 9, box 10, antialias 8, width-1 7:4, colour 3:0.
// - Valid clear disables engine; valid plus box draws a rectangle.
// - Arc descriptor: 22 bytes, type C2h, centre, radius, start, sweep.
// - Arc overlay 0..1, engine 0..4, width 1..16, radius 1..65535.
// - Angles are float degrees; negative sweep runs counter-clockwise.
// - Arc control: valid 9, antialias 8, width-1 7:4, colour 3:0.
// - Shapes render with their overlay palette entry chosen by colour index.
// - Command 8219h writes one of four separate 16-entry palettes.
// - Palette params: type, overlay, start 0..15, count 1..16, then words.
// - Bad palette type, overlay, start, count, start+count over 16, missing words or pool overflow give invalid, otherwise success.
// - Command 821Ah stores data bytes from a 16-bit offset, bounded length.
// - Glyph write answers busy while overlays enabled, invalid for bad args.
// - Glyph memory: 64 chars of 128 bytes, char N is string index 192+N.
module osc_unit (
    input wire logic SYS_CLK,
    input wire logic RESETN,
    input wire logic [7:0] REG_ADDR,
    input wire logic [31:0] REG_WDATA,
    input wire logic REG_WR,
    input wire logic REG_RD,
    output logic [31:0] REG_RDATA,
    input wire logic FRAME_BLANK,
    output logic OVL_ENABLE,
    output logic ENG_WR,
    output logic ENG_ARC,
    output logic ENG_OVERLAY,
    output logic [3:0] ENG_INDEX,
    output logic ENG_ENABLE,
    output logic ENG_BOX,
    output logic ENG_AA,
    output logic [4:0] ENG_WIDTH,
    output logic [3:0] ENG_COLOR,
    output logic ENG_CCW,
    output logic [31:0] ENG_P0,
    output logic [31:0] ENG_P1,
    output logic [31:0] ENG_P2,
    output logic [31:0] ENG_P3,
    output logic [31:0] ENG_P4,
    output logic PAL_WR,
    output logic PAL_ARC,
    output logic PAL_OVERLAY,
    output logic [3:0] PAL_INDEX,
    output logic [31:0] PAL_DATA,
    output logic GLY_WR,
    output logic [12:0] GLY_ADDR,
    output logic [7:0] GLY_DATA,
    output logic [7:0] GLY_CHAR
);
    logic rst_meta_r;
    logic rst_n;
    logic [7:0] pool_r [osc_pkg::POOL_CAP];
    logic [7:0] fill_r;
    logic ovf_r;
    logic [15:0] cmd_r;
    logic [7:0] res_r;
    logic ovl_en_r;
    osc_pkg::osc_state_t st_r;
    logic [7:0] ptr_r;
    logic [3:0] idx_r;
    logic [15:0] cnt_r;
    logic [12:0] gaddr_r;
    logic busy;
    logic cmd_wr;

    logic [7:0] d_type;
    logic [7:0] d_hdr;
    logic [15:0] d_cw;
    logic [7:0] d_len;
    logic [8:0] d_end;
    logic d_fits;
    logic d_line_ok;
    logic d_arc_ok;
    logic pal_ok;
    logic [15:0] g_off;
    logic [15:0] g_len;
    logic g_ok;

    // Release is synchronous so no flop sees a partial reset edge
    always_ff @(posedge SYS_CLK or negedge RESETN) begin
        if (!RESETN) begin
            rst_meta_r <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_meta_r <= 1'b1;
            rst_n <= rst_meta_r;
        end
    end

    function automatic logic [7:0] pb(input logic [7:0] i);
        logic [7:0] v;
        v = 8'h00;
        if (i < osc_pkg::POOL_CAP_B) begin
            v = pool_r[i[osc_pkg::POOL_AW-1:0]];
        end
        return v;
    endfunction

    function automatic logic [15:0] w16(input logic [7:0] i);
        return {pb(i), pb(i + 8'h01)};
    endfunction

    function automatic logic [31:0] w32(input logic [7:0] i);
        return {w16(i), w16(i + 8'h02)};
    endfunction

    assign busy = (st_r != osc_pkg::ST_IDLE);
    assign cmd_wr = REG_WR && (REG_ADDR == osc_pkg::REG_CMD) && !busy;

    always_comb begin
        d_type = pb(ptr_r);
        d_hdr = pb(ptr_r + 8'h01);
        d_cw = w16(ptr_r + 8'h02);
        d_len = 8'h00;
        if (d_type == osc_pkg::DESC_LINE) begin
            d_len = osc_pkg::LINE_LEN;
        end else if (d_type == osc_pkg::DESC_ARC) begin
            d_len = osc_pkg::ARC_LEN;
        end
    end

    // Terminator byte must also lie inside the filled pool
    assign d_end = {1'b0, ptr_r} + {1'b0, d_len};
    assign d_fits = d_end < {1'b0, fill_r};
    assign d_line_ok = d_fits && (d_hdr[7:4] <= osc_pkg::OVL_MAX)
        && (d_hdr[3:0] <= osc_pkg::LINE_ENG_MAX);
    assign d_arc_ok = d_fits && (d_hdr[7:4] <= osc_pkg::OVL_MAX)
        && (d_hdr[3:0] <= osc_pkg::ARC_ENG_MAX) && (w16(ptr_r + 8'h0C) != 16'h0000);

    always_comb begin
        pal_ok = (fill_r >= osc_pkg::PAL_HDR_LEN) && (pool_r[0] <= 8'h01)
            && (pool_r[1] <= 8'h01) && (pool_r[2] < {3'h0, osc_pkg::PAL_ENTRIES})
            && (pool_r[3] != 8'h00) && (pool_r[3] <= {3'h0, osc_pkg::PAL_ENTRIES})
            && ({1'b0, pool_r[2]} + {1'b0, pool_r[3]} <= {4'h0, osc_pkg::PAL_ENTRIES})
            && ({2'h0, pool_r[3], 2'h0} + 12'h004 <= {4'h0, fill_r});
    end

    assign g_off = w16(8'h00);
    assign g_len = w16(8'h02);
    assign g_ok = (fill_r >= osc_pkg::PAL_HDR_LEN) && (g_len <= osc_pkg::GLYPH_LEN_MAX)
        && ({1'b0, g_len} + 17'h00004 <= {9'h000, fill_r})
        && ({1'b0, g_off} + {1'b0, g_len} <= osc_pkg::GLYPH_BYTES);

    // Parameter pool; pushes while busy are dropped so a running command sees fixed data
    always_ff @(posedge SYS_CLK or negedge rst_n) begin
        if (!rst_n) begin
            fill_r <= 8'h00;
            ovf_r <= 1'b0;
        end else if (st_r == osc_pkg::ST_DONE) begin
            fill_r <= 8'h00;
            ovf_r <= 1'b0;
        end else if (REG_WR && (REG_ADDR == osc_pkg::REG_PARAM) && !busy) begin
            if (fill_r < osc_pkg::POOL_CAP_B) begin
                fill_r <= fill_r + 8'h01;
            end else begin
                ovf_r <= 1'b1;
            end
        end
    end

    generate
        for (genvar g = 0; g < osc_pkg::POOL_CAP; g++) begin : g_pool
            always_ff @(posedge SYS_CLK or negedge rst_n) begin
                if (!rst_n) begin
                    pool_r[g] <= 8'h00;
                end else if (REG_WR && (REG_ADDR == osc_pkg::REG_PARAM) && !busy
                        && (fill_r == 8'(g))) begin
                    pool_r[g] <= REG_WDATA[7:0];
                end
            end
        end
    endgenerate

    // Control register frozen while a command runs
    always_ff @(posedge SYS_CLK or negedge rst_n) begin
        if (!rst_n) begin
            ovl_en_r <= osc_pkg::CTRL_RST;
            cmd_r <= osc_pkg::CMD_RST;
        end else begin
            if (REG_WR && (REG_ADDR == osc_pkg::REG_CTRL) && !busy) begin
                ovl_en_r <= REG_WDATA[0];
            end
            if (cmd_wr) begin
                cmd_r <= REG_WDATA[15:0];
            end
        end
    end

    always_ff @(posedge SYS_CLK or negedge rst_n) begin
        if (!rst_n) begin
            REG_RDATA <= 32'h00000000;
        end else if (REG_RD) begin
            case (REG_ADDR)
                osc_pkg::REG_CMD: REG_RDATA <= {16'h0000, cmd_r};
                osc_pkg::REG_STATUS: REG_RDATA <= {7'h00, ovf_r, fill_r, res_r, 7'h00, busy};
                osc_pkg::REG_CTRL: REG_RDATA <= {31'h00000000, ovl_en_r};
                default: REG_RDATA <= 32'h00000000;
            endcase
        end else begin
            REG_RDATA <= 32'h00000000;
        end
    end

    // Command sequencer
    always_ff @(posedge SYS_CLK or negedge rst_n) begin
        if (!rst_n) begin
            st_r <= osc_pkg::ST_IDLE;
            res_r <= osc_pkg::RES_RST;
            ptr_r <= 8'h00;
            idx_r <= 4'h0;
            cnt_r <= 16'h0000;
            gaddr_r <= 13'h0000;
        end else begin
            case (st_r)
                osc_pkg::ST_IDLE: begin
                    ptr_r <= 8'h00;
                    if (cmd_wr) begin
                        case (REG_WDATA[15:0])
                            osc_pkg::CMD_SHAPE_DRAW: st_r <= osc_pkg::ST_SHAPE_CHECK;
                            osc_pkg::CMD_PALETTE_WRITE: st_r <= osc_pkg::ST_PAL_CHECK;
                            osc_pkg::CMD_GLYPH_WRITE: st_r <= osc_pkg::ST_GLY_CHECK;
                            default: begin
                                res_r <= osc_pkg::RES_INVALID;
                                st_r <= osc_pkg::ST_DONE;
                            end
                        endcase
                    end
                end
                // Whole list validated before any engine is touched
                osc_pkg::ST_SHAPE_CHECK: begin
                    if (ovf_r || (ptr_r >= fill_r)) begin
                        res_r <= osc_pkg::RES_INVALID;
                        st_r <= osc_pkg::ST_DONE;
                    end else if (d_type == osc_pkg::DESC_END) begin
                        ptr_r <= 8'h00;
                        st_r <= osc_pkg::ST_SHAPE_APPLY;
                    end else if ((d_type == osc_pkg::DESC_LINE && d_line_ok)
                            || (d_type == osc_pkg::DESC_ARC && d_arc_ok)) begin
                        ptr_r <= d_end[7:0];
                    end else begin
                        res_r <= osc_pkg::RES_INVALID;
                        st_r <= osc_pkg::ST_DONE;
                    end
                end
                osc_pkg::ST_SHAPE_APPLY: begin
                    if (d_type == osc_pkg::DESC_END) begin
                        res_r <= osc_pkg::RES_SUCCESS;
                        st_r <= osc_pkg::ST_DONE;
                    end else if (FRAME_BLANK) begin
                        ptr_r <= d_end[7:0];
                    end
                end
                osc_pkg::ST_PAL_CHECK: begin
                    ptr_r <= osc_pkg::PAL_HDR_LEN;
                    idx_r <= pool_r[2][3:0];
                    cnt_r <= {8'h00, pool_r[3]};
                    if (pal_ok && !ovf_r) begin
                        st_r <= osc_pkg::ST_PAL_WRITE;
                    end else begin
                        res_r <= osc_pkg::RES_INVALID;
                        st_r <= osc_pkg::ST_DONE;
                    end
                end
                osc_pkg::ST_PAL_WRITE: begin
                    ptr_r <= ptr_r + 8'h04;
                    idx_r <= idx_r + 4'h1;
                    cnt_r <= cnt_r - 16'h0001;
                    if (cnt_r == 16'h0001) begin
                        res_r <= osc_pkg::RES_SUCCESS;
                        st_r <= osc_pkg::ST_DONE;
                    end
                end
                osc_pkg::ST_GLY_CHECK: begin
                    ptr_r <= osc_pkg::PAL_HDR_LEN;
                    cnt_r <= g_len;
                    gaddr_r <= g_off[12:0];
                    if (ovl_en_r) begin
                        res_r <= osc_pkg::RES_BUSY;
                        st_r <= osc_pkg::ST_DONE;
                    end else if (!g_ok || ovf_r) begin
                        res_r <= osc_pkg::RES_INVALID;
                        st_r <= osc_pkg::ST_DONE;
                    end else if (g_len == 16'h0000) begin
                        res_r <= osc_pkg::RES_SUCCESS;
                        st_r <= osc_pkg::ST_DONE;
                    end else begin
                        st_r <= osc_pkg::ST_GLY_WRITE;
                    end
                end
                osc_pkg::ST_GLY_WRITE: begin
                    ptr_r <= ptr_r + 8'h01;
                    gaddr_r <= gaddr_r + 13'h0001;
                    cnt_r <= cnt_r - 16'h0001;
                    if (cnt_r == 16'h0001) begin
                        res_r <= osc_pkg::RES_SUCCESS;
                        st_r <= osc_pkg::ST_DONE;
                    end
                end
                osc_pkg::ST_DONE: st_r <= osc_pkg::ST_IDLE;
                default: st_r <= osc_pkg::ST_IDLE;
            endcase
        end
    end

    // Engine write port, one descriptor per blanking cycle
    always_ff @(posedge SYS_CLK or negedge rst_n) begin
        if (!rst_n) begin
            ENG_WR <= 1'b0;
            ENG_ARC <= 1'b0;
            ENG_OVERLAY <= 1'b0;
            ENG_INDEX <= 4'h0;
            ENG_ENABLE <= 1'b0;
            ENG_BOX <= 1'b0;
            ENG_AA <= 1'b0;
            ENG_WIDTH <= 5'h00;
            ENG_COLOR <= 4'h0;
            ENG_CCW <= 1'b0;
            ENG_P0 <= 32'h00000000;
            ENG_P1 <= 32'h00000000;
            ENG_P2 <= 32'h00000000;
            ENG_P3 <= 32'h00000000;
            ENG_P4 <= 32'h00000000;
        end else begin
            ENG_WR <= 1'b0;
            if ((st_r == osc_pkg::ST_SHAPE_APPLY) && FRAME_BLANK
                    && (d_type != osc_pkg::DESC_END)) begin
                ENG_WR <= 1'b1;
                ENG_ARC <= (d_type == osc_pkg::DESC_ARC);
                ENG_OVERLAY <= d_hdr[4];
                ENG_INDEX <= d_hdr[3:0];
                ENG_ENABLE <= d_cw[osc_pkg::CW_VALID];
                ENG_AA <= d_cw[osc_pkg::CW_AA];
                ENG_WIDTH <= {1'b0, d_cw[osc_pkg::CW_WID_LSB +: 4]} + 5'h01;
                ENG_COLOR <= d_cw[3:0];
                ENG_BOX <= (d_type == osc_pkg::DESC_LINE) && d_cw[osc_pkg::CW_VALID]
                    && d_cw[osc_pkg::CW_BOX];
                if (d_type == osc_pkg::DESC_LINE) begin
                    ENG_CCW <= 1'b0;
                    ENG_P0 <= {16'h0000, w16(ptr_r + 8'h04)};
                    ENG_P1 <= {16'h0000, w16(ptr_r + 8'h06)};
                    ENG_P2 <= {16'h0000, w16(ptr_r + 8'h08)};
                    ENG_P3 <= {16'h0000, w16(ptr_r + 8'h0A)};
                    ENG_P4 <= 32'h00000000;
                end else begin
                    ENG_CCW <= pb(ptr_r + 8'h12) >= 8'h80;
                    ENG_P0 <= w32(ptr_r + 8'h04);
                    ENG_P1 <= w32(ptr_r + 8'h08);
                    ENG_P2 <= {16'h0000, w16(ptr_r + 8'h0C)};
                    ENG_P3 <= w32(ptr_r + 8'h0E);
                    ENG_P4 <= w32(ptr_r + 8'h12);
                end
            end
        end
    end

    // Palette and glyph write ports
    always_ff @(posedge SYS_CLK or negedge rst_n) begin
        if (!rst_n) begin
            PAL_WR <= 1'b0;
            PAL_ARC <= 1'b0;
            PAL_OVERLAY <= 1'b0;
            PAL_INDEX <= 4'h0;
            PAL_DATA <= 32'h00000000;
            GLY_WR <= 1'b0;
            GLY_ADDR <= 13'h0000;
            GLY_DATA <= 8'h00;
            GLY_CHAR <= 8'h00;
        end else begin
            // separate table per type and overlay
            PAL_WR <= (st_r == osc_pkg::ST_PAL_WRITE);
            if (st_r == osc_pkg::ST_PAL_WRITE) begin
                PAL_ARC <= pool_r[0][0];
                PAL_OVERLAY <= pool_r[1][0];
                PAL_INDEX <= idx_r;
                PAL_DATA <= w32(ptr_r);
            end
            GLY_WR <= (st_r == osc_pkg::ST_GLY_WRITE);
            if (st_r == osc_pkg::ST_GLY_WRITE) begin
                GLY_ADDR <= gaddr_r;
                GLY_DATA <= pb(ptr_r);
                GLY_CHAR <= osc_pkg::GLYPH_INDEX_BASE + {2'h0, gaddr_r[12:osc_pkg::GLYPH_CHAR_LSB]};
            end
        end
    end

    assign OVL_ENABLE = ovl_en_r;

    default clocking cb @(posedge SYS_CLK);
    endclocking
    default disable iff (!rst_n);

    property p_apply_in_blank;
        ENG_WR |-> $past(FRAME_BLANK) && $past(st_r) == osc_pkg::ST_SHAPE_APPLY;
    endproperty
    a_apply_in_blank: assert property (p_apply_in_blank) else $error("engine written outside blanking");

    property p_line_range;
        ENG_WR && !ENG_ARC |-> ENG_INDEX <= 4'h9;
    endproperty
    a_line_range: assert property (p_line_range) else $error("line engine out of range");

    property p_arc_range;
        ENG_WR && ENG_ARC |-> ENG_INDEX <= 4'h4 && ENG_P2[15:0] != 16'h0000;
    endproperty
    a_arc_range: assert property (p_arc_range) else $error("arc engine or radius bad");

    property p_box;
        ENG_WR && ENG_BOX |-> ENG_ENABLE && !ENG_ARC;
    endproperty
    a_box: assert property (p_box) else $error("box set without valid line");

    property p_ccw;
        ENG_WR && ENG_ARC |-> ENG_CCW == ENG_P4[31];
    endproperty
    a_ccw: assert property (p_ccw) else $error("sweep direction wrong");

    property p_pal_seq;
        PAL_WR && $past(PAL_WR) |-> PAL_INDEX == $past(PAL_INDEX) + 4'h1;
    endproperty
    a_pal_seq: assert property (p_pal_seq) else $error("palette index not stepping");

    property p_glyph_guard;
        GLY_WR |-> !OVL_ENABLE;
    endproperty
    a_glyph_guard: assert property (p_glyph_guard) else $error("glyph write with overlays on");

    property p_glyph_char;
        GLY_WR |-> GLY_CHAR == 8'hC0 + {2'h0, GLY_ADDR[12:7]};
    endproperty
    a_glyph_char: assert property (p_glyph_char) else $error("glyph string index wrong");

    property p_term;
        st_r == osc_pkg::ST_SHAPE_CHECK && !ovf_r && ptr_r < fill_r && d_type == 8'h00
            |=> st_r == osc_pkg::ST_SHAPE_APPLY ##[0:300] st_r == osc_pkg::ST_DONE;
    endproperty
    a_term: assert property (p_term) else $error("terminator not honoured");

    property p_bad_type;
        st_r == osc_pkg::ST_SHAPE_CHECK && d_type != 8'h00 && d_type != 8'hC1
            && d_type != 8'hC2 |=> st_r == osc_pkg::ST_DONE && res_r == osc_pkg::RES_INVALID;
    endproperty
    a_bad_type: assert property (p_bad_type) else $error("unknown descriptor accepted");

    c_line: cover property (ENG_WR && !ENG_ARC && ENG_BOX);
    c_arc: cover property (ENG_WR && ENG_ARC && ENG_CCW);
    c_pal: cover property (PAL_WR ##1 PAL_WR);
    c_gly_busy: cover property (st_r == osc_pkg::ST_DONE && res_r == osc_pkg::RES_BUSY);
endmodule

// ===== tb/osc_host.sv
`timescale 1ns/1ns
module osc_host (
    input wire logic clk,
    input wire logic [31:0] rdata,
    output logic [7:0] addr,
    output logic [31:0] wdata,
    output logic wr,
    output logic rd
);
    initial begin
        addr = 8'h00;
        wdata = 32'h0;
        wr = 1'b0;
        rd = 1'b0;
    end
    task automatic write(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    // Data stands one cycle only
    task automatic read(input logic [7:0] a, output logic [31:0] d);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        @(posedge clk);
        d = rdata;
    endtask
endmodule

// ===== tb/osc_unit_tb.sv
`timescale 1ns/1ns
module osc_unit_tb;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic fb = 1'b0;
    logic [7:0] a;
    logic [31:0] wd;
    logic [31:0] rdat;
    logic [31:0] st;
    logic wr;
    logic rd;
    int fail_count = 0;
    int n_compared = 0;
    int eng_n = 0;
    int pal_n = 0;
    logic [18:0] e_f;
    logic [159:0] e_p;
    logic [31:0] rv;
    logic [35:0] p_v;
    logic [28:0] g_v;
    osc_host host (.clk(clk), .rdata(rdat), .addr(a), .wdata(wd), .wr(wr), .rd(rd));
    osc_unit uut (.SYS_CLK(clk), .RESETN(rst_n), .REG_ADDR(a), .REG_WDATA(wd),
        .REG_WR(wr), .REG_RD(rd), .REG_RDATA(rdat), .FRAME_BLANK(fb), .OVL_ENABLE(),
        .ENG_WR(), .ENG_ARC(), .ENG_OVERLAY(), .ENG_INDEX(), .ENG_ENABLE(), .ENG_BOX(),
        .ENG_AA(), .ENG_WIDTH(), .ENG_COLOR(), .ENG_CCW(), .ENG_P0(), .ENG_P1(),
        .ENG_P2(), .ENG_P3(), .ENG_P4(), .PAL_WR(), .PAL_ARC(), .PAL_OVERLAY(),
        .PAL_INDEX(), .PAL_DATA(), .GLY_WR(), .GLY_ADDR(), .GLY_DATA(), .GLY_CHAR());
    initial forever #25 clk = ~clk;
    always @(posedge clk) begin
        if (uut.ENG_WR === 1'b1) begin
            eng_n++;
            e_f = {uut.ENG_ARC, uut.ENG_OVERLAY, uut.ENG_INDEX, uut.ENG_ENABLE,
                uut.ENG_BOX, uut.ENG_AA, uut.ENG_WIDTH, uut.ENG_COLOR, uut.ENG_CCW};
            e_p = {uut.ENG_P0, uut.ENG_P1, uut.ENG_P2, uut.ENG_P3, uut.ENG_P4};
        end
        if (uut.PAL_WR === 1'b1) begin
            pal_n++;
            p_v = {uut.PAL_INDEX, uut.PAL_DATA};
        end
        if (uut.GLY_WR === 1'b1)
            g_v = {uut.GLY_ADDR, uut.GLY_DATA, uut.GLY_CHAR};
    end
    task chk(input string n, input logic [35:0] e, input logic [35:0] g);
        n_compared++;
        if (g !== e) begin
            $display("[ERR] %s expected %h seen %h", n, e, g);
            fail_count++;
        end
    endtask
    task summarize;
        $display("compared %0d mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    // Bytes go out most significant first
    // lists kept within pool
    task pv(input logic [95:0] v, input int n);
        for (int i = n - 1; i >= 0; i--)
            host.write(osc_pkg::REG_PARAM, {24'h000000, v[i*8+:8]});
    endtask
    task go(input logic [15:0] c);
        host.write(osc_pkg::REG_CMD, {16'h0000, c});
    endtask
    task fin(input logic [7:0] res, input string n);
        for (int i = 0; i < 200 && st[0] !== 1'b0; i++)
            host.read(osc_pkg::REG_STATUS, st);
        if (st[0] !== 1'b0) begin
            fail_count++;
            summarize;
        end
        chk(n, {28'h0, res}, {28'h0, st[15:8]});
        st = 32'h1;
    endtask
    task t_pal;
        pv(96'h00_01_03_01_11223344, 8);
        go(osc_pkg::CMD_PALETTE_WRITE);
        fin(osc_pkg::RES_SUCCESS, "pal res");
        chk("pal wr", {4'h3, 32'h11223344}, p_v);
        chk("pal sel", 36'h1, {uut.PAL_ARC, uut.PAL_OVERLAY});
        pv(96'h01_00_00_10, 4);
        for (int i = 0; i < 16; i++)
            pv({64'h0, 32'h0A0B0C00 | 32'(i)}, 4);
        go(osc_pkg::CMD_PALETTE_WRITE);
        fin(osc_pkg::RES_SUCCESS, "pal full");
        chk("pal last", {4'hF, 32'h0A0B0C0F}, p_v);
        chk("pal sel arc", 36'h2, {uut.PAL_ARC, uut.PAL_OVERLAY});
        pv(96'h00_00_10_01_11223344, 8);
        go(osc_pkg::CMD_PALETTE_WRITE);
        fin(osc_pkg::RES_INVALID, "pal bad");
        chk("pal n", 36'h11, pal_n);
        $display("palette test done");
    endtask
    task t_shape;
        pv(96'hC1_13_06A5_0102_0304_0506_0708, 12);
        pv(96'h0, 1);
        go(osc_pkg::CMD_SHAPE_DRAW);
        repeat (20) @(posedge clk);
        chk("eng unblanked", 36'h0, eng_n);
        fb <= 1'b1;
        fin(osc_pkg::RES_SUCCESS, "shape res");
        chk("eng f", {1'b0, 1'b1, 4'h3, 3'b110, 5'h0B, 4'h5, 1'b0}, e_f);
        chk("eng x0", 36'h102, e_p[159:128]);
        chk("eng y0 y1", 36'h03040708, {e_p[111:96], e_p[47:32]});
        pv(96'hC2_04_01F2_FFFFFFF6_00000014, 12);
        pv(96'h0001_42B40000_C2340000_00, 11);
        go(osc_pkg::CMD_SHAPE_DRAW);
        fin(osc_pkg::RES_SUCCESS, "arc res");
        chk("arc f", {1'b1, 1'b0, 4'h4, 3'b001, 5'h10, 4'h2, 1'b1}, e_f);
        chk("arc x", 36'hFFFFFFF6, e_p[159:128]);
        chk("arc y", 36'h14, e_p[127:96]);
        chk("arc r", 36'h1, e_p[95:64]);
        chk("arc start", 36'h42B40000, e_p[63:32]);
        chk("arc sweep", 36'hC2340000, e_p[31:0]);
        pv(96'hC1_0A_0200_0000_0000_0000_0000, 12);
        pv(96'h0, 1);
        go(osc_pkg::CMD_SHAPE_DRAW);
        fin(osc_pkg::RES_INVALID, "bad eng");
        pv(96'hC2_00_0200_00000000_00000000, 12);
        pv(96'h0, 11);
        go(osc_pkg::CMD_SHAPE_DRAW);
        fin(osc_pkg::RES_INVALID, "arc r0");
        pv(96'h55_00, 2);
        go(osc_pkg::CMD_SHAPE_DRAW);
        fin(osc_pkg::RES_INVALID, "bad type");
        chk("eng n", 36'h2, eng_n);
        $display("shape test done");
    endtask
    task t_gly;
        host.write(osc_pkg::REG_CTRL, 32'h1);
        host.read(osc_pkg::REG_CTRL, rv);
        chk("ovl en", 36'h3, {rv[0], uut.OVL_ENABLE});
        pv(96'h0080_0001_AA, 5);
        go(osc_pkg::CMD_GLYPH_WRITE);
        fin(osc_pkg::RES_BUSY, "gly busy");
        host.write(osc_pkg::REG_CTRL, 32'h0);
        pv(96'h0080_0001_AA, 5);
        go(osc_pkg::CMD_GLYPH_WRITE);
        fin(osc_pkg::RES_SUCCESS, "gly res");
        chk("gly", {13'h0080, 8'hAA, 8'hC1}, g_v);
        pv({64'h0, 16'h0000, osc_pkg::GLYPH_LEN_MAX + 16'h0001}, 4);
        go(osc_pkg::CMD_GLYPH_WRITE);
        fin(osc_pkg::RES_INVALID, "gly len");
        $display("glyph test done");
    endtask
    initial begin
        st = 32'h1;
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge clk);
        t_pal;
        t_shape;
        t_gly;
        summarize;
    end
endmodule
